/* bench/tb_top.sv */
// Self-checking bench for the oscillator/PLL control block.
// Assumes a zero-wait APB slave and clock sources sampled on core_clk_i.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam int LIM = 20000;  // Cycle ceiling of the whole run
  logic        clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0;  // Clock, reset, bus controls
  logic [31:0] pa = 0, pwd = 0, prd, rd, ctl, exp_c;  // Bus words, control word model
  logic [2:0]  prot = 0;  // Protection code of a transfer
  logic        rdy, er, err, ill, frc, ca, cb, ca_q = 0, cb_q = 0;  // Answers, outputs
  logic        tz = 0, lpe = 0, pis = 0, stk = 0, lvl = 0;  // Side inputs, source level
  logic [1:0]  bsel = 0, dsv, v, exp_d;  // Second source pick, voltage model
  logic [4:0]  stb = 0;  // Oscillator and PLL stable flags
  logic [7:0]  cal = 0;  // Factory calibration byte
  logic [15:0] psec = 0, pen_o;  // Peripheral security and enables
  int          failures = 0, samples_checked = 0, cyc = 0, n_ill = 0, n_a = 0, n_b = 0, a0, b0;

  // Only the chosen second-output source toggles, so edges prove the mux
  opc_top uut (
    .core_clk_i(clk), .rst_i(rst), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr),
    .paddr_i(pa), .pwdata_i(pwd), .pstrb_i(4'hF), .pprot_i(prot), .prdata_o(prd),
    .pready_o(rdy), .pslverr_o(err), .tz_enable_i(tz), .low_power_entry_i(lpe),
    .main_pll_is_sys_i(pis), .digital_pll_is_sys_i(pis), .rc_stable_i(stb[0]),
    .main_xtal_stable_i(stb[1]), .main_pll_stable_i(stb[2]), .audio_pll_stable_i(stb[3]),
    .digital_pll_stable_i(stb[4]), .rc_factory_calibration_i(cal), .xtal_stuck_i(stk),
    .periph_secure_i(psec), .clkout_a_src_i(lvl), .sys_clk_i(lvl & (bsel == 2'h0)),
    .audio_pll_clock_i(lvl & (bsel == 2'h1)), .main_xtal_clk_i(lvl & (bsel == 2'h2)),
    .digital_pll_clock_i(lvl & (bsel == 2'h3)), .ctrl_o(ctl), .deep_sleep_voltage_sel_o(dsv),
    .periph_enable_o(pen_o), .sys_force_rc_o(frc), .illegal_access_o(ill),
    .clock_output_a_o(ca), .clock_output_b_o(cb));

  ////////////////////////////////////////////////////////////////////////////////
  // Clock, event counters and hang guard
  always #4 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (ill === 1'b1) n_ill <= n_ill + 1;  // Long pulses count once per high cycle
    if (ca === 1'b1 && ca_q === 1'b0) n_a <= n_a + 1;
    if (cb === 1'b1 && cb_q === 1'b0) n_b <= n_b + 1;
    ca_q <= ca;
    cb_q <= cb;
    if (cyc == LIM) begin
      failures++;
      print_verdict();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Expectation helpers
  function automatic logic [31:0] view(input logic [31:0] c);  // Read view of control
    view = (c & ~32'h0A82FF02) | {16'h0, cal, 8'h00} | (32'(stb[0]) << 1)
         | (32'(stb[1]) << 17) | (32'(stb[2]) << 25) | (32'(stb[3]) << 27) | (32'(stb[4]) << 23);
  endfunction : view
  function automatic int rat(input logic [2:0] c);  // Divide ratio of a code
    rat = c[2] ? int'(c[1:0]) + 2 : 1;
  endfunction : rat
  function automatic logic [31:0] cw();  // Writable part of the control word
    cw = ctl & opc_pkg::CTL_RW;
  endfunction : cw

  task automatic check(input string nm, input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      failures++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask : check

  // One APB transfer; returns one edge after the access so outputs have settled
  task automatic apb(input logic w, input logic [11:0] o, input logic ns,
                     input logic [31:0] d, input logic pv = 1'b1);
    @(posedge clk);
    psel <= 1'b1;
    pwr  <= w;
    pwd  <= d;
    prot <= {1'b0, ns, pv};
    pa   <= {ns ? opc_pkg::NS_PAGE : opc_pkg::SEC_PAGE, o};
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (rdy !== 1'b1);
    rd = prd;
    er = err;
    psel <= 1'b0;
    pen  <= 1'b0;
    @(posedge clk);
  endtask : apb

  task automatic run(input int n);  // n source periods of four cycles
    repeat (2 * n) begin
      repeat (2) @(posedge clk);
      lvl <= ~lvl;
    end
  endtask : run

  task automatic print_verdict();
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : print_verdict

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    void'($urandom(32'hE9F5798C));
    cal  <= 8'($urandom);
    stb  <= 5'($urandom);
    psec <= 16'($urandom);
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    check("ctrl reset", cw(), opc_pkg::CTL_RESET & opc_pkg::CTL_RW);
    apb(1'b0, opc_pkg::OFS_CTL, 1'b0, 32'h0);
    check("ctrl read", rd, view(opc_pkg::CTL_RESET));
    exp_c = 32'h85780001 | (32'($urandom_range(0, 31)) << 3);
    apb(1'b1, opc_pkg::OFS_CTL, 1'b0, exp_c);
    check("ctrl write", cw(), exp_c);
    pis <= 1'b1;
    apb(1'b1, opc_pkg::OFS_CTL, 1'b0, exp_c & ~32'h01300000);
    check("pll hold", cw(), exp_c);
    pis <= 1'b0;
    lpe <= 1'b1;
    @(posedge clk);
    lpe <= 1'b0;
    @(posedge clk);
    exp_c = exp_c & ~opc_pkg::LP_CLEAR;
    check("low power", cw(), exp_c);
    apb(1'b1, opc_pkg::OFS_CTL, 1'b0, (exp_c & ~32'h80000000) | 32'h50000000);
    exp_c = exp_c | 32'h50000000;
    check("xtal lock", cw(), exp_c);
    stk <= 1'b1;
    @(posedge clk);
    stk <= 1'b0;
    @(posedge clk);
    check("force rc", frc, 1'b1);
    apb(1'b1, opc_pkg::OFS_MONITOR, 1'b0, 32'h1);
    check("force clear", frc, 1'b0);
    // Wrong key, right key, then no key: only the second update lands
    exp_d = 2'h0;
    for (int i = 0; i < 3; i++) begin
      v = exp_d ^ 2'($urandom_range(1, 3));
      if (i < 2) apb(1'b1, opc_pkg::OFS_VKEY, 1'b0, opc_pkg::VOLT_KEY ^ 32'(i == 0));
      if (i == 1) exp_d = v;
      apb(1'b1, opc_pkg::OFS_DSV, 1'b0, {30'h0, v});
      check("voltage", dsv, exp_d);
    end
    // Security on: RC and system-clock resources secured
    tz <= 1'b1;
    apb(1'b1, opc_pkg::OFS_SECP, 1'b0, 32'h9);
    apb(1'b0, opc_pkg::OFS_SECSTAT, 1'b0, 32'h0);
    check("sec status", rd, 32'h9);
    a0 = n_ill;
    apb(1'b0, opc_pkg::OFS_SECP, 1'b1, 32'h0);
    check("ns cfg read", rd, 32'h0);
    apb(1'b1, opc_pkg::OFS_SECP, 1'b1, 32'h0);
    apb(1'b0, opc_pkg::OFS_CTL, 1'b1, 32'h0);
    check("ns ctrl read", rd, view(exp_c) & ~opc_pkg::SM_RC);
    apb(1'b1, opc_pkg::OFS_CTL, 1'b1, exp_c ^ 32'hF8);
    check("ns ctrl write", cw(), exp_c);
    apb(1'b1, opc_pkg::OFS_PERIPH, 1'b1, 32'hFFFF);
    check("periph gate", pen_o, {16'h0, ~psec});
    apb(1'b0, opc_pkg::OFS_SECP, 1'b0, 32'h0);
    check("cfg kept", rd, 32'h9);
    check("illegal events", 32'(n_ill - a0), 32'h2);
    tz <= 1'b0;
    apb(1'b0, opc_pkg::OFS_SECP, 1'b0, 32'h0);
    check("cfg off", rd, 32'h0);
    exp_c = exp_c ^ 32'hF8;
    apb(1'b1, opc_pkg::OFS_CTL, 1'b1, exp_c);
    check("ns ctrl open", cw(), exp_c);
    // Privilege protection set, then cleared
    exp_c = exp_c | 32'h4;
    apb(1'b1, opc_pkg::OFS_CTL, 1'b0, exp_c);
    apb(1'b0, opc_pkg::OFS_CTL, 1'b0, 32'h0, 1'b0);
    check("unpriv read", rd, 32'h0);
    apb(1'b1, opc_pkg::OFS_CTL, 1'b0, exp_c ^ 32'hFC, 1'b0);
    check("unpriv write", cw(), exp_c);
    exp_c = exp_c & ~32'h4;
    apb(1'b1, opc_pkg::OFS_CTL, 1'b0, exp_c);
    apb(1'b1, opc_pkg::OFS_CTL, 1'b0, exp_c ^ 32'hFC, 1'b0);
    exp_c = exp_c ^ 32'hF8;
    check("unpriv priv bit", cw(), exp_c);
    apb(1'b0, 12'h0FC, 1'b0, 32'h0);
    check("unmapped err", 32'(er), 32'h1);
    check("unmapped data", rd, 32'h0);
    // Every divide code on both outputs, every source of the second
    for (int k = 0; k < 8; k++) begin
      apb(1'b1, opc_pkg::OFS_CLKOUT, 1'b0, {k[1:0], 3'(7 - k), k[2:0], 24'h0});
      bsel <= k[1:0];
      run(3);
      a0 = n_a;
      b0 = n_b;
      run(40);
      check("clock a", 32'((n_a - a0 - 40 / rat(k[2:0]) + 1) inside {[0:2]}), 32'h1);
      check("clock b", 32'((n_b - b0 - 40 / rat(3'(7 - k)) + 1) inside {[0:2]}), 32'h1);
    end
    print_verdict();
  end
endmodule : tb_top
`default_nettype wire

/* logic/opc_pkg.sv */
// Constants and carrier types for the oscillator/PLL control block.
// Assumes a 32-bit APB slave with registers on aligned words.
package opc_pkg;
  // Register byte offsets within either alias page
  localparam logic [11:0] OFS_CTL     = 12'h000;
  localparam logic [11:0] OFS_CLKOUT  = 12'h008;
  localparam logic [11:0] OFS_SECP    = 12'h010;
  localparam logic [11:0] OFS_SECSTAT = 12'h014;
  localparam logic [11:0] OFS_PERIPH  = 12'h018;
  localparam logic [11:0] OFS_MONITOR = 12'h01C;
  localparam logic [11:0] OFS_VKEY    = 12'h030;
  localparam logic [11:0] OFS_DSV     = 12'h034;
  // Alias pages, address bits 31:12
  localparam logic [19:0] SEC_PAGE = 20'h50023;
  localparam logic [19:0] NS_PAGE  = 20'h40023;
  // Unlock key of the deep-sleep voltage register
  localparam logic [31:0] VOLT_KEY = 32'h1A2B3C4D;
  // Control register bit positions
  localparam int B_READY = 31;
  localparam int B_XPLL  = 30;
  localparam int B_XAUD  = 29;
  localparam int B_XPU   = 28;
  localparam int B_ASTB  = 27;
  localparam int B_AEN   = 26;
  localparam int B_PSTB  = 25;
  localparam int B_PEN   = 24;
  localparam int B_DSTB  = 23;
  localparam int B_RFMON = 22;
  localparam int B_DEN   = 21;
  localparam int B_DPU   = 20;
  localparam int B_XMON  = 19;
  localparam int B_XSTB  = 17;
  localparam int B_XEN   = 16;
  localparam int B_CAL   = 8;
  localparam int B_PRIV  = 2;
  localparam int B_RSTB  = 1;
  // Control register reset value and software-writable bits
  localparam logic [31:0] CTL_RESET = 32'h00000083;
  localparam logic [31:0] CTL_RW    = 32'hF57900FD;
  // Bits dropped by hardware on deep-sleep or standby entry
  localparam logic [31:0] LP_CLEAR  = 32'h75100000;
  // Per-resource secured bits of the control register
  localparam logic [31:0] SM_RC    = 32'h0000FFFB;
  localparam logic [31:0] SM_XTAL  = 32'hF04B0000;
  localparam logic [31:0] SM_PLL   = 32'h03000000;
  localparam logic [31:0] SM_DPLL  = 32'h00B00000;
  localparam logic [31:0] SM_AUDIO = 32'h0C000000;
  // Security configuration bit positions
  localparam int S_RC = 0;
  localparam int S_XTAL = 1;
  localparam int S_LOWSPD = 2;
  localparam int S_SYSCLK = 3;
  localparam int S_PRESC = 4;
  localparam int S_PLL = 5;
  localparam int S_DPLL = 6;
  localparam int S_RSTF = 7;
  localparam int S_BKP = 8;
  localparam int S_AUDIO = 9;
  localparam int SECP_W = 10;
  // Clock-output field base, divide-code reset and deep-sleep voltage reset
  localparam int B_CLKOUT = 24;
  localparam logic [2:0] DIV_CODE_RESET = 3'h0;
  localparam logic [1:0] DSV_RESET = 2'h0;
  // Clock-output configuration, register bits 31:24
  typedef struct packed {
    logic [1:0] sel_b;  // Second output source
    logic [2:0] div_b;  // clkout_b_divide
    logic [2:0] div_a;  // clkout_a_divide
  } opc_clkout_type;
endpackage : opc_pkg

/* logic/opc_top.sv */
// Oscillator/PLL control register block with security and privilege gating.
// Assumes APB inputs synchronous to core_clk_i and clock sources sampled as levels.
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// Clock-output divider: ratio 1 for codes 0xx, 2..5 for codes 100..111
module opc_clk_divider (
  input  wire logic       core_clk_i,
  input  wire logic       rst_i,
  input  wire logic       src_i,
  input  wire logic [2:0] code_i,
  output logic            out_o
);
  logic       src_d;    // Previous source level
  logic [2:0] cnt;      // Source edge counter
  logic [2:0] next_cnt;
  logic       next_out;
  logic [2:0] ratio;

  // Counter wraps at the ratio; output high for the first half
  always_comb begin
    ratio    = code_i[2] ? {1'b0, code_i[1:0]} + 3'h2 : 3'h1;
    next_cnt = cnt;
    next_out = out_o;
    if (ratio == 3'h1) begin
      next_cnt = 3'h0;
      next_out = src_i;
    end else if (src_i && !src_d) begin
      next_cnt = (cnt >= ratio - 3'h1) ? 3'h0 : cnt + 3'h1;
      // Odd ratios give a high phase one edge longer
      next_out = (next_cnt < ((ratio + 3'h1) >> 1));
    end
  end

  // Registers; synchronous reset
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      src_d <= 1'b0;
      cnt   <= 3'h0;
      out_o <= 1'b0;
    end else begin
      src_d <= src_i;
      cnt   <= next_cnt;
      out_o <= next_out;
    end
  end
endmodule : opc_clk_divider

////////////////////////////////////////////////////////////////////////////////
module opc_top #(
  parameter int PERIPH_N = 16  // Peripheral clock-enable bits
) (
  input  wire logic                core_clk_i,
  input  wire logic                rst_i,
  input  wire logic                psel_i,
  input  wire logic                penable_i,
  input  wire logic                pwrite_i,
  input  wire logic [31:0]         paddr_i,
  input  wire logic [31:0]         pwdata_i,
  input  wire logic [3:0]          pstrb_i,
  input  wire logic [2:0]          pprot_i,
  output logic [31:0]              prdata_o,
  output logic                     pready_o,
  output logic                     pslverr_o,
  input  wire logic                tz_enable_i,
  input  wire logic                low_power_entry_i,
  input  wire logic                main_pll_is_sys_i,
  input  wire logic                digital_pll_is_sys_i,
  input  wire logic                rc_stable_i,
  input  wire logic                main_xtal_stable_i,
  input  wire logic                main_pll_stable_i,
  input  wire logic                audio_pll_stable_i,
  input  wire logic                digital_pll_stable_i,
  input  wire logic [7:0]          rc_factory_calibration_i,
  input  wire logic                xtal_stuck_i,
  input  wire logic [PERIPH_N-1:0] periph_secure_i,
  input  wire logic                clkout_a_src_i,
  input  wire logic                sys_clk_i,
  input  wire logic                audio_pll_clock_i,
  input  wire logic                main_xtal_clk_i,
  input  wire logic                digital_pll_clock_i,
  output logic [31:0]              ctrl_o,
  output logic [1:0]               deep_sleep_voltage_sel_o,
  output logic [PERIPH_N-1:0]      periph_enable_o,
  output logic                     sys_force_rc_o,
  output logic                     illegal_access_o,
  output logic                     clock_output_a_o,
  output logic                     clock_output_b_o
);
  if (PERIPH_N < 1 || PERIPH_N > 32) begin : g_chk
    $error("PERIPH_N must lie in 1..32");
  end

  // Register state
  logic                       unlock;       // Voltage key seen
  logic [opc_pkg::SECP_W-1:0] secp;         // security_config_reg
  opc_pkg::opc_clkout_type    clkout;       // Clock-output fields
  logic                       next_unlock;
  logic [31:0]                next_ctrl;
  logic [1:0]                 next_dsv;
  logic [PERIPH_N-1:0]        next_periph;
  logic [opc_pkg::SECP_W-1:0] next_secp;
  opc_pkg::opc_clkout_type    next_clkout;
  logic                       next_force;
  logic [31:0]                next_rdata;
  logic                       next_ready;
  logic                       next_err;
  logic                       next_illegal;
  // Decode helpers
  logic [11:0] ofs;
  logic        page_sec, mapped, secure, unpriv_blk, wr_go, is_secp;
  logic [31:0] bmask, ctl_sec, ctl_view, wm, pmask;
  logic        clk_b_src;

  // Address decode and access attributes
  always_comb begin
    ofs      = paddr_i[11:0];
    page_sec = (paddr_i[31:12] == opc_pkg::SEC_PAGE);
    mapped   = (page_sec || paddr_i[31:12] == opc_pkg::NS_PAGE) &&
               (ofs == opc_pkg::OFS_CTL || ofs == opc_pkg::OFS_CLKOUT ||
                ofs == opc_pkg::OFS_SECP || ofs == opc_pkg::OFS_SECSTAT ||
                ofs == opc_pkg::OFS_PERIPH || ofs == opc_pkg::OFS_MONITOR ||
                ofs == opc_pkg::OFS_VKEY || ofs == opc_pkg::OFS_DSV);
    // Security off makes every access behave as secure toward the bits
    secure     = !tz_enable_i || (page_sec && !pprot_i[1]);
    is_secp    = (ofs == opc_pkg::OFS_SECP);
    unpriv_blk = ctrl_o[opc_pkg::B_PRIV] && !pprot_i[0] &&
                 ofs != opc_pkg::OFS_SECSTAT;
    bmask = {{8{pstrb_i[3]}}, {8{pstrb_i[2]}}, {8{pstrb_i[1]}}, {8{pstrb_i[0]}}};
    wr_go = psel_i && penable_i && pready_o && pwrite_i && mapped && !unpriv_blk;
    // Secured control bits per configured resource
    ctl_sec = (secp[opc_pkg::S_RC] ? opc_pkg::SM_RC : 32'h0) |
              (secp[opc_pkg::S_XTAL] ? opc_pkg::SM_XTAL : 32'h0) |
              (secp[opc_pkg::S_PLL] ? opc_pkg::SM_PLL : 32'h0) |
              (secp[opc_pkg::S_DPLL] ? opc_pkg::SM_DPLL : 32'h0) |
              (secp[opc_pkg::S_AUDIO] ? opc_pkg::SM_AUDIO : 32'h0);
    pmask = 32'h0;
    pmask[PERIPH_N-1:0] = periph_secure_i;
    ctl_view = ctrl_o;  // Hardware status merged into the read view
    ctl_view[opc_pkg::B_ASTB] = audio_pll_stable_i;
    ctl_view[opc_pkg::B_PSTB] = main_pll_stable_i;
    ctl_view[opc_pkg::B_DSTB] = digital_pll_stable_i;
    ctl_view[opc_pkg::B_XSTB] = main_xtal_stable_i;
    ctl_view[opc_pkg::B_RSTB] = rc_stable_i;
    ctl_view[opc_pkg::B_CAL+7:opc_pkg::B_CAL] = rc_factory_calibration_i;
    // Read data, captured in the setup cycle
    case (ofs)
      opc_pkg::OFS_CTL:     next_rdata = ctl_view & (secure ? 32'hFFFFFFFF : ~ctl_sec);
      opc_pkg::OFS_CLKOUT:  next_rdata = (secure || !secp[opc_pkg::S_SYSCLK]) ?
                                         {clkout, 24'h0} : 32'h0;
      opc_pkg::OFS_SECP,
      opc_pkg::OFS_SECSTAT: next_rdata = (tz_enable_i && secure) ?
                                         {22'h0, secp} : 32'h0;
      opc_pkg::OFS_PERIPH:  next_rdata = 32'(periph_enable_o) &
                                         (secure ? 32'hFFFFFFFF : ~pmask);
      opc_pkg::OFS_MONITOR: next_rdata = {31'h0, sys_force_rc_o &
                                         (secure || !secp[opc_pkg::S_XTAL])};
      opc_pkg::OFS_DSV:     next_rdata = {30'h0, deep_sleep_voltage_sel_o};
      default:              next_rdata = 32'h0;  // Key and unmapped read zero
    endcase
    if (unpriv_blk || !mapped) begin
      next_rdata = 32'h0;
    end
    if (!(psel_i && !penable_i)) begin
      next_rdata = prdata_o;
    end
    next_ready = psel_i && !penable_i;  // Zero wait states
    next_err   = psel_i && !penable_i && !mapped;
    // One pulse per nonsecure touch of the security configuration
    next_illegal = psel_i && penable_i && pready_o && mapped && is_secp &&
                   tz_enable_i && !secure;
  end

  // Register update
  always_comb begin
    next_ctrl   = ctrl_o;
    next_dsv    = deep_sleep_voltage_sel_o;
    next_periph = periph_enable_o;
    next_secp   = secp;
    next_clkout = clkout;
    next_unlock = unlock;
    next_force  = sys_force_rc_o;
    wm          = bmask & (secure ? 32'hFFFFFFFF : ~ctl_sec);
    if (!pprot_i[0]) begin
      wm[opc_pkg::B_PRIV] = 1'b0;
    end
    if (wr_go) begin
      case (ofs)
        opc_pkg::OFS_CTL: begin
          next_ctrl = ((ctrl_o & ~wm) | (pwdata_i & wm)) & opc_pkg::CTL_RW;
          if (ctrl_o[opc_pkg::B_XEN] || ctrl_o[opc_pkg::B_XPLL] ||
              ctrl_o[opc_pkg::B_XAUD] || ctrl_o[opc_pkg::B_DEN]) begin
            next_ctrl[opc_pkg::B_READY] = ctrl_o[opc_pkg::B_READY];
          end else begin
            next_ctrl[opc_pkg::B_XPU] = ctrl_o[opc_pkg::B_XPU];
          end
          if (ctrl_o[opc_pkg::B_PEN]) begin
            next_ctrl[opc_pkg::B_XPLL] = ctrl_o[opc_pkg::B_XPLL];
          end
          if (ctrl_o[opc_pkg::B_AEN]) begin
            next_ctrl[opc_pkg::B_XAUD] = ctrl_o[opc_pkg::B_XAUD];
          end
          if (main_pll_is_sys_i && ctrl_o[opc_pkg::B_PEN]) begin
            next_ctrl[opc_pkg::B_PEN] = 1'b1;
          end
          if (digital_pll_is_sys_i && ctrl_o[opc_pkg::B_DEN]) begin
            next_ctrl[opc_pkg::B_DEN] = 1'b1;
          end
          if (digital_pll_is_sys_i && ctrl_o[opc_pkg::B_DPU]) begin
            next_ctrl[opc_pkg::B_DPU] = 1'b1;
          end
        end
        opc_pkg::OFS_CLKOUT: if (secure || !secp[opc_pkg::S_SYSCLK]) begin
          next_clkout = (bmask[31]) ? pwdata_i[31:24] : clkout;
        end
        opc_pkg::OFS_SECP: if (tz_enable_i && secure && bmask[0] && bmask[8]) begin
          next_secp = pwdata_i[opc_pkg::SECP_W-1:0];
        end
        opc_pkg::OFS_PERIPH: begin
          next_periph = (periph_enable_o & ~(bmask[PERIPH_N-1:0] &
                        (secure ? {PERIPH_N{1'b1}} : ~periph_secure_i))) |
                        (pwdata_i[PERIPH_N-1:0] & bmask[PERIPH_N-1:0] &
                        (secure ? {PERIPH_N{1'b1}} : ~periph_secure_i));
        end
        opc_pkg::OFS_MONITOR: if ((secure || !secp[opc_pkg::S_XTAL]) &&
                                  pwdata_i[0] && bmask[0]) begin
          next_force = 1'b0;  // Write one clears the stuck flag
        end
        opc_pkg::OFS_VKEY: next_unlock = (pwdata_i == opc_pkg::VOLT_KEY);
        opc_pkg::OFS_DSV: begin
          if (unlock && bmask[0]) begin
            next_dsv = pwdata_i[1:0];
          end
          next_unlock = 1'b0;  // Every update needs a new key
        end
        default: next_unlock = unlock;
      endcase
    end
    // Hardware events win over software in the same cycle
    if (low_power_entry_i) begin
      next_ctrl = next_ctrl & ~opc_pkg::LP_CLEAR;
    end
    if (xtal_stuck_i && ctrl_o[opc_pkg::B_XMON]) begin
      next_force = 1'b1;
    end
  end

  // State registers; synchronous reset
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      ctrl_o                   <= opc_pkg::CTL_RESET;
      deep_sleep_voltage_sel_o <= opc_pkg::DSV_RESET;
      periph_enable_o          <= '0;
      secp                     <= '0;
      clkout                   <= '0;
      unlock                   <= 1'b0;
      sys_force_rc_o           <= 1'b0;
      prdata_o                 <= 32'h0;
      pready_o                 <= 1'b0;
      pslverr_o                <= 1'b0;
      illegal_access_o         <= 1'b0;
    end else begin
      ctrl_o                   <= next_ctrl;
      deep_sleep_voltage_sel_o <= next_dsv;
      periph_enable_o          <= next_periph;
      secp                     <= next_secp;
      clkout                   <= next_clkout;
      unlock                   <= next_unlock;
      sys_force_rc_o           <= next_force;
      prdata_o                 <= next_rdata;
      pready_o                 <= next_ready;
      pslverr_o                <= next_err;
      illegal_access_o         <= next_illegal;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Second output source mux; crystal monitor enables leave via ctrl_o
  always_comb begin
    case (clkout.sel_b)
      2'h0:    clk_b_src = sys_clk_i;
      2'h1:    clk_b_src = audio_pll_clock_i;
      2'h2:    clk_b_src = main_xtal_clk_i;
      2'h3:    clk_b_src = digital_pll_clock_i;
      default: clk_b_src = sys_clk_i;
    endcase
  end

  // Dividers: sources toggle far below core_clk_i or they alias
  opc_clk_divider u_div_a (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .src_i      (clkout_a_src_i),
    .code_i     (clkout.div_a),
    .out_o      (clock_output_a_o)
  );
  opc_clk_divider u_div_b (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .src_i      (clk_b_src),
    .code_i     (clkout.div_b),
    .out_o      (clock_output_b_o)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  sequence s_setup;
    psel_i && !penable_i;
  endsequence
  sequence s_unpriv_rd;
    s_setup ##0 (!pwrite_i && !pprot_i[0] && ctrl_o[opc_pkg::B_PRIV] &&
                 ofs != opc_pkg::OFS_SECSTAT);
  endsequence

  a_ready_one_cycle: assert property (s_setup |=> pready_o ##1 !pready_o)
    else $error("pready not a single cycle after setup");
  a_key_guard: assert property ($changed(deep_sleep_voltage_sel_o) |-> $past(unlock)
                                && !unlock)
    else $error("voltage changed without key");
  a_lowpower_clear: assert property (low_power_entry_i |=>
                                     (ctrl_o & opc_pkg::LP_CLEAR) == 32'h0)
    else $error("lowpower entry left enables set");
  a_pll_hold: assert property (main_pll_is_sys_i && ctrl_o[opc_pkg::B_PEN] &&
                               !low_power_entry_i |=> ctrl_o[opc_pkg::B_PEN])
    else $error("main PLL cleared while clocking system");
  a_dpll_hold: assert property (digital_pll_is_sys_i && ctrl_o[opc_pkg::B_DEN] |=>
                                ctrl_o[opc_pkg::B_DEN])
    else $error("digital PLL cleared while clocking system");
  a_ready_lock: assert property ($changed(ctrl_o[opc_pkg::B_READY]) |->
                                 !$past(ctrl_o[opc_pkg::B_XEN]) &&
                                 !$past(ctrl_o[opc_pkg::B_XPLL]) &&
                                 !$past(ctrl_o[opc_pkg::B_XAUD]) &&
                                 !$past(ctrl_o[opc_pkg::B_DEN]))
    else $error("ready bit changed while locked");
  a_illegal_pulse: assert property (illegal_access_o |=> !illegal_access_o)
    else $error("illegal access pulse too long");
  a_monitor_force: assert property (xtal_stuck_i && ctrl_o[opc_pkg::B_XMON] |=>
                                    sys_force_rc_o)
    else $error("stuck crystal did not force RC");
  a_unpriv_raz: assert property (s_unpriv_rd |=> prdata_o == 32'h0)
    else $error("unprivileged read returned data");
  a_tzoff_secp: assert property (s_setup ##0 (!tz_enable_i && is_secp) |=>
                                 prdata_o == 32'h0)
    else $error("security config readable with security off");
endmodule : opc_top

`default_nettype wire
